/* rsml_pkg.sv */
// Purpose: shared constants and types of the strap mode latch
// Assumes: seven shared strap pins, register bus is APB with 32-bit data
// Notes: pin index order is the same for straps, pads and pull controls
package rsml_pkg;
  localparam int NUM_STRAPS = 7;
  // strap and pad positions
  localparam int BIT_BOOT = 0;
  localparam int BIT_IRQ = 1;
  localparam int BIT_LINK = 2;
  localparam int BIT_POLICY = 3;
  localparam int BIT_TM_A = 4;
  localparam int BIT_TM_B = 5;
  localparam int BIT_TM_C = 6;
  // pull patterns per pin
  localparam logic [6:0] PD_IN_RESET = 7'h0f;
  localparam logic [6:0] PU_IN_RESET = 7'h70;
  localparam logic [6:0] PU_IN_NORMAL = 7'h09;
  localparam logic [6:0] ID0_ONLY = 7'h09;
  // register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_STRAP_STATUS = 12'h000;
  localparam logic [11:0] OFS_SYSTEM_CFG = 12'h004;
  localparam logic [11:0] OFS_SDRAM_CFG = 12'h008;
  localparam logic [11:0] OFS_LOCK_STATUS = 12'h00c;
  // field positions
  localparam int STAT_NORMAL_BIT = 7;
  localparam int LOCK_SYS_BIT = 0;
  localparam int LOCK_SDR_BIT = 1;
  localparam int LOCK_POLICY_BIT = 2;
  // reset values
  localparam logic [31:0] SYSTEM_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SDRAM_CFG_RST = 32'h0000_0000;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PIN_RETURN_NS = 16;
  localparam int PIN_RETURN_CYC = (PIN_RETURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PIN_RETURN_LAST = 2'(PIN_RETURN_CYC - 1);
  typedef enum logic [1:0] {PH_HOLD, PH_SETTLE, PH_NORMAL} rsml_phase_t;
endpackage : rsml_pkg

/* rsml_strap_if.sv */
// Purpose: carries captured straps and pin phase between the two modules
// Assumes: single clock domain
// Notes: driven only by the capture unit
`timescale 1ns/100ps
`default_nettype none
interface rsml_strap_if;
  logic [6:0] straps;
  logic normalMode;
  modport capture (output straps, output normalMode);
  modport user (input straps, input normalMode);
endinterface : rsml_strap_if
`default_nettype wire

/* rsml_strap_capture.sv */
// Purpose: samples strap pads through reset and times the return of the pins
// Assumes: pads synchronous to mclk, nrst is the external reset level
// Notes: the last sample taken while nrst is low is the one kept
`timescale 1ns/100ps
`default_nettype none
module rsml_strap_capture (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // pad levels
  input wire logic [6:0] padIn,
  // results
  rsml_strap_if.capture sif
);
  rsml_pkg::rsml_phase_t phase_q;
  logic [1:0] cnt_q;
  logic [6:0] straps_q;

  genvar g;
  generate
    for (g = 0; g < rsml_pkg::NUM_STRAPS; g++) begin : g_bit
      // one flop per pin, sampled each reset cycle with ce high, frozen once released
      always_ff @(posedge mclk) begin
        if (!nrst && ce) begin // [R12]
          straps_q[g] <= padIn[g]; // [R1] [R2] [R4]
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_q <= rsml_pkg::PH_HOLD;
      cnt_q <= 2'h0;
    end else if (ce) begin
      case (phase_q)
        rsml_pkg::PH_HOLD: begin
          phase_q <= rsml_pkg::PH_SETTLE;
          cnt_q <= 2'h0;
        end
        rsml_pkg::PH_SETTLE: begin
          if (cnt_q == rsml_pkg::PIN_RETURN_LAST) begin
            phase_q <= rsml_pkg::PH_NORMAL; // [R3]
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        rsml_pkg::PH_NORMAL: begin
          phase_q <= rsml_pkg::PH_NORMAL;
        end
        default: begin
          phase_q <= rsml_pkg::PH_HOLD;
        end
      endcase
    end
  end

  assign sif.straps = straps_q;
  assign sif.normalMode = (phase_q == rsml_pkg::PH_NORMAL);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence releaseSeq;
    $rose(nrst) && ce ##1 ce ##1 ce;
  endsequence

  a_capture_at_release: assert property ($rose(nrst) && $past(ce) |-> straps_q == $past(padIn)) // [R1]
    else $error("straps differ from pads at release");
  a_pin_return_time: assert property (releaseSeq |=> sif.normalMode) // [R3]
    else $error("pins not returned in time");
  a_no_early_return: assert property ($rose(nrst) |-> !sif.normalMode ##1 !sif.normalMode) // [R3]
    else $error("pins returned too early");
  a_straps_stable: assert property (nrst && $past(nrst) |-> $stable(straps_q)) // [R12]
    else $error("straps changed outside reset");
endmodule : rsml_strap_capture
`default_nettype wire

/* rsml_strap_latch.sv */
// Purpose: strap mode latch top with pad control and APB register access
// Assumes: nrst follows the external reset input, all inputs on mclk
// Notes: two config registers obey the strapped write policy
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [R1] Every strap level is captured as reset releases and held as the mode selection.
// [R2] Each strap pin has its own mode bit, captured independently of the others.
// [R3] Shortly after release every shared pin returns to its normal function.
// [R4] With no overdrive, the internal reset-time pull sets the captured default.
// [R5] Boot strap 0 boots from external memory, 1 waits for an outside boot agent.
// [R6] Interrupt strap 0 leaves the four inputs disabled and level, 1 enables them as edge.
// [R7] Link width strap 0 selects 1-bit receive width, 1 selects 4-bit.
// [R8] Policy strap 0 allows one write to the two config registers, 1 allows any number.
// [R9] The board must leave the three test straps at their pull-up default in reset.
// [R10] Pull settings follow the reset level: one set in reset, another afterwards.
// [R11] Boot and bus hold pins go pulldown to pullup on id zero only; the others become driven.
// [R12] Captured straps stay fixed from release until reset is asserted again.
module rsml_strap_latch (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // processor identity
  input wire logic procIdZero,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared pads
  input wire logic [6:0] padIn,
  output logic [6:0] padOut,
  output logic [6:0] padOe,
  output logic [6:0] pullUpEn,
  output logic [6:0] pullDnEn,
  // normal pin functions from the core
  input wire logic [6:0] funcOut,
  input wire logic [6:0] funcOe,
  // operating modes
  output logic bootExternalWait,
  output logic extIrqEnable,
  output logic extIrqEdge,
  output logic linkRxWidth4,
  output logic cfgAlwaysWritable,
  output logic [2:0] testMode,
  output logic pinsNormal,
  // configuration registers
  output logic [31:0] systemConfigReg,
  output logic [31:0] sdramConfigReg
);
  rsml_strap_if sif ();

  rsml_strap_capture u_capture (
    .mclk (mclk),
    .nrst (nrst),
    .ce (ce),
    .padIn (padIn),
    .sif (sif)
  );

  function automatic logic addrHit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction : addrHit

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // mode decode straight from the captured flops
  logic policyAlways;
  assign policyAlways = sif.straps[rsml_pkg::BIT_POLICY];
  assign bootExternalWait = sif.straps[rsml_pkg::BIT_BOOT]; // [R5]
  assign extIrqEnable = sif.straps[rsml_pkg::BIT_IRQ]; // [R6]
  assign extIrqEdge = sif.straps[rsml_pkg::BIT_IRQ]; // [R6]
  assign linkRxWidth4 = sif.straps[rsml_pkg::BIT_LINK]; // [R7]
  assign cfgAlwaysWritable = policyAlways; // [R8]
  // relies on the board leaving these at the pull-up level
  assign testMode = sif.straps[rsml_pkg::BIT_TM_C:rsml_pkg::BIT_TM_A]; // [R9]
  assign pinsNormal = sif.normalMode;

  // pad drive and pulls
  logic [6:0] padOut_q;
  logic [6:0] padOe_q;
  logic [6:0] pullUp_q;
  logic [6:0] pullDn_q;

  genvar g;
  generate
    for (g = 0; g < rsml_pkg::NUM_STRAPS; g++) begin : g_pad
      logic idOk;
      assign idOk = procIdZero | ~rsml_pkg::ID0_ONLY[g];

      always_ff @(posedge mclk) begin
        if (!nrst) begin
          padOut_q[g] <= 1'b0;
          padOe_q[g] <= 1'b0;
        end else if (ce) begin
          padOut_q[g] <= funcOut[g];
          // pads stay inputs until the capture unit lets go
          padOe_q[g] <= sif.normalMode & funcOe[g]; // [R3]
        end
      end

      always_ff @(posedge mclk) begin
        if (!nrst) begin
          pullDn_q[g] <= rsml_pkg::PD_IN_RESET[g] & idOk; // [R4] [R10] [R11]
          pullUp_q[g] <= rsml_pkg::PU_IN_RESET[g]; // [R4] [R10]
        end else if (ce) begin
          pullDn_q[g] <= 1'b0; // [R10]
          pullUp_q[g] <= rsml_pkg::PU_IN_NORMAL[g] & idOk; // [R11]
        end
      end
    end
  endgenerate

  assign padOut = padOut_q;
  assign padOe = padOe_q;
  assign pullUpEn = pullUp_q;
  assign pullDnEn = pullDn_q;

  // apb decode
  logic setupPh;
  logic accessPh;
  logic wrAccess;
  logic hitStatus;
  logic hitSys;
  logic hitSdr;
  logic hitLock;
  logic sysWrOk;
  logic sdrWrOk;

  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrAccess = accessPh & pwrite;
  assign hitStatus = addrHit(paddr, rsml_pkg::OFS_STRAP_STATUS);
  assign hitSys = addrHit(paddr, rsml_pkg::OFS_SYSTEM_CFG);
  assign hitSdr = addrHit(paddr, rsml_pkg::OFS_SDRAM_CFG);
  assign hitLock = addrHit(paddr, rsml_pkg::OFS_LOCK_STATUS);

  logic [31:0] sysCfg_q;
  logic [31:0] sdrCfg_q;
  logic sysDone_q;
  logic sdrDone_q;

  // one write after reset unless the policy strap says always
  assign sysWrOk = ~sysDone_q | policyAlways; // [R8]
  assign sdrWrOk = ~sdrDone_q | policyAlways; // [R8]

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sysCfg_q <= rsml_pkg::SYSTEM_CFG_RST;
      sysDone_q <= 1'b0;
    end else if (ce && wrAccess && hitSys && sysWrOk) begin
      sysCfg_q <= mergeBytes(sysCfg_q, pwdata, pstrb); // [R8]
      sysDone_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sdrCfg_q <= rsml_pkg::SDRAM_CFG_RST;
      sdrDone_q <= 1'b0;
    end else if (ce && wrAccess && hitSdr && sdrWrOk) begin
      sdrCfg_q <= mergeBytes(sdrCfg_q, pwdata, pstrb); // [R8]
      sdrDone_q <= 1'b1;
    end
  end

  assign systemConfigReg = sysCfg_q;
  assign sdramConfigReg = sdrCfg_q;

  // read data and error prepared in setup, presented in access
  logic [31:0] rdata_d;
  logic err_d;
  logic [31:0] prdata_q;
  logic pslverr_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (hitStatus) begin
      rdata_d[6:0] = sif.straps;
      rdata_d[rsml_pkg::STAT_NORMAL_BIT] = sif.normalMode;
      err_d = pwrite;
    end else if (hitSys) begin
      rdata_d = sysCfg_q;
      err_d = pwrite & ~sysWrOk;
    end else if (hitSdr) begin
      rdata_d = sdrCfg_q;
      err_d = pwrite & ~sdrWrOk;
    end else if (hitLock) begin
      rdata_d[rsml_pkg::LOCK_SYS_BIT] = sysDone_q;
      rdata_d[rsml_pkg::LOCK_SDR_BIT] = sdrDone_q;
      rdata_d[rsml_pkg::LOCK_POLICY_BIT] = policyAlways;
      err_d = pwrite;
    end else begin
      err_d = 1'b1;
    end
    if (pwrite) begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce && setupPh) begin
      prdata_q <= rdata_d;
      pslverr_q <= err_d;
    end
  end

  // zero wait states; ce low stretches nothing on the bus side
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & accessPh;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence lockedSysWrite;
    ce && wrAccess && hitSys && sysDone_q && !policyAlways;
  endsequence

  sequence freeSysWrite;
    ce && wrAccess && hitSys && policyAlways && (pstrb == 4'hf);
  endsequence

  sequence statusRead;
    ce && setupPh && !pwrite && hitStatus;
  endsequence

  sequence releaseEdge;
    $rose(nrst) && $past(ce);
  endsequence

  sequence lockedSdrWrite;
    ce && wrAccess && hitSdr && sdrDone_q && !policyAlways;
  endsequence

  sequence refusedSetup;
    ce && setupPh && pwrite && (hitStatus || hitLock || (hitSys && !sysWrOk) || (hitSdr && !sdrWrOk));
  endsequence

  sequence firstSysSetup;
    ce && setupPh && pwrite && hitSys && !sysDone_q;
  endsequence

  sequence lockRead;
    ce && setupPh && !pwrite && hitLock;
  endsequence

  sequence drivingPhase;
    ce && sif.normalMode;
  endsequence

  sequence frozenCycle;
    nrst && !ce;
  endsequence

  a_cfg_write_once: assert property (lockedSysWrite |=> $stable(sysCfg_q)) // [R8]
    else $error("locked config register changed");
  a_cfg_write_free: assert property (freeSysWrite |=> sysCfg_q == $past(pwdata)) // [R8]
    else $error("config write lost under always policy");
  a_lock_sets: assert property (ce && wrAccess && hitSdr |=> sdrDone_q) // [R8]
    else $error("write flag not set");
  a_pull_after: assert property (nrst && $past(nrst) && $past(ce) // [R10] [R11]
    |-> pullDnEn == 7'h00 && pullUpEn == (rsml_pkg::PU_IN_NORMAL & {7{$past(procIdZero)}}))
    else $error("pull setting wrong after reset");
  a_drive_gated: assert property (padOe != 7'h00 |-> $past(sif.normalMode)) // [R3]
    else $error("pad driven before pins returned");
  a_status_read: assert property (statusRead ##1 accessPh |-> prdata[6:0] == $past(sif.straps)) // [R1]
    else $error("status read differs from straps");
  a_modes_follow: assert property (releaseEdge |-> linkRxWidth4 == $past(padIn[rsml_pkg::BIT_LINK]) // [R5] [R7]
    && bootExternalWait == $past(padIn[rsml_pkg::BIT_BOOT]))
    else $error("mode outputs differ from straps");
  a_unmapped_err: assert property (ce && setupPh && !(hitStatus || hitSys || hitSdr || hitLock)
    ##1 accessPh |-> pslverr)
    else $error("unmapped access not flagged");

  // capture, pads and bus at the release edge, then pads once driving
  a_mode_capture: assert property (releaseEdge |-> extIrqEnable == $past(padIn[rsml_pkg::BIT_IRQ]) // [R6] [R8]
    && extIrqEdge == $past(padIn[rsml_pkg::BIT_IRQ])
    && cfgAlwaysWritable == $past(padIn[rsml_pkg::BIT_POLICY]))
    else $error("interrupt or policy mode not captured");
  a_test_capture: assert property (releaseEdge // [R2] [R4]
    |-> testMode == $past(padIn[rsml_pkg::BIT_TM_C:rsml_pkg::BIT_TM_A]))
    else $error("test mode not captured");
  a_pull_reset: assert property ($rose(nrst) |-> pullUpEn == rsml_pkg::PU_IN_RESET // [R4] [R10] [R11]
    && pullDnEn == (rsml_pkg::PD_IN_RESET & ~(rsml_pkg::ID0_ONLY & {7{!$past(procIdZero)}})))
    else $error("pull setting wrong in reset");
  a_quiet_release: assert property ($rose(nrst) |-> padOe == 7'h00) // [R3]
    else $error("pad driven at release");
  a_pad_follow: assert property (drivingPhase |=> padOe == $past(funcOe) && padOut == $past(funcOut)) // [R3] [R11]
    else $error("pad does not follow its normal function");
  a_release_idle_bus: assert property ($rose(nrst) |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("bus outputs not cleared by reset");

  // register policy and bus answers
  a_sdr_write_once: assert property (lockedSdrWrite |=> $stable(sdrCfg_q)) // [R8]
    else $error("locked sdram config register changed");
  a_refused_err: assert property (refusedSetup ##1 accessPh |-> pslverr) // [R8]
    else $error("refused write not flagged");
  a_first_write_ok: assert property (firstSysSetup ##1 accessPh |-> !pslverr) // [R8]
    else $error("first config write refused");
  a_sys_write_lands: assert property (ce && wrAccess && hitSys && sysWrOk && pstrb == 4'hf // [R8]
    |=> sysCfg_q == $past(pwdata))
    else $error("accepted config write lost");
  a_sdr_write_lands: assert property (ce && wrAccess && hitSdr && sdrWrOk && pstrb == 4'hf // [R8]
    |=> sdrCfg_q == $past(pwdata))
    else $error("accepted sdram write lost");
  a_lock_sys: assert property (ce && wrAccess && hitSys |=> sysDone_q) // [R8]
    else $error("system write flag not set");
  a_lock_read: assert property (lockRead ##1 accessPh // [R8]
    |-> prdata[rsml_pkg::LOCK_SYS_BIT] == $past(sysDone_q) && prdata[rsml_pkg::LOCK_SDR_BIT] == $past(sdrDone_q)
    && prdata[rsml_pkg::LOCK_POLICY_BIT] == $past(policyAlways))
    else $error("lock status read wrong");
  a_status_normal: assert property (statusRead ##1 accessPh // [R3]
    |-> prdata[rsml_pkg::STAT_NORMAL_BIT] == $past(sif.normalMode))
    else $error("status shows wrong pin phase");

  // a low enable freezes registers, pulls and pads alike
  a_ce_freeze: assert property (frozenCycle |=> $stable(sysCfg_q) && $stable(sdrCfg_q) && $stable(sif.straps)
    && $stable(pullUpEn) && $stable(pullDnEn) && $stable(padOe) && $stable(sif.normalMode))
    else $error("state moved while enable low");
  a_modes_stable: assert property (nrst && $past(nrst) |-> $stable({bootExternalWait, extIrqEnable, // [R12]
    linkRxWidth4, cfgAlwaysWritable, testMode}))
    else $error("mode outputs changed outside reset");
endmodule : rsml_strap_latch
`default_nettype wire

/* rsml_board_model.sv */
// Purpose: board side of the strap pins, strap resistors and pad wire level
// Assumes: a board strap beats an internal pull, a driving pad beats both
// Notes: a pin nobody holds shows the inverse of its last level
`timescale 1ns/100ps
`default_nettype none
module rsml_board_model (
  // clock
  input wire logic mclk,
  // board straps
  input wire logic [6:0] strapEn,
  input wire logic [6:0] strapVal,
  // device pad side
  input wire logic [6:0] padOut,
  input wire logic [6:0] padOe,
  input wire logic [6:0] pullUpEn,
  input wire logic [6:0] pullDnEn,
  output logic [6:0] padLevel
);
  logic [6:0] lastQ;
  logic [6:0] boardEn;
  // test straps are left to the internal pull-up
  assign boardEn = strapEn & 7'h0f;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (padOe[i]) begin
        padLevel[i] = padOut[i];
      end else if (boardEn[i]) begin
        padLevel[i] = strapVal[i];
      end else if (pullUpEn[i]) begin
        padLevel[i] = 1'b1;
      end else if (pullDnEn[i]) begin
        padLevel[i] = 1'b0;
      end else begin
        padLevel[i] = ~lastQ[i];
      end
    end
  end
  always_ff @(posedge mclk) begin
    lastQ <= padLevel;
  end
endmodule : rsml_board_model
`default_nettype wire

/* rsml_strap_latch_tb.sv */
// Purpose: self-checking bench of the strap mode latch
// Assumes: ce high but for one frozen write per pass, full byte strobes on every write
// Notes: random straps come from a fixed-seed shift register
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin numErrors++; \
  $display("mismatch %s exp=%h got=%h", nm, ex, got); end end
module rsml_strap_latch_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic procIdZero = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [6:0] funcOut = 7'h00;
  logic [6:0] funcOe = 7'h00;
  logic [6:0] strapEn = 7'h00;
  logic [6:0] strapVal = 7'h00;
  logic [6:0] padIn, padOut, padOe, pullUpEn, pullDnEn;
  logic [31:0] prdata, systemConfigReg, sdramConfigReg;
  logic pready, pslverr, bootExternalWait, extIrqEnable, extIrqEdge, linkRxWidth4, cfgAlwaysWritable, pinsNormal;
  logic [2:0] testMode;
  logic [31:0] seed = 32'h0001_2c68;
  int numErrors = 0;
  int totalChecks = 0;

  always #4 mclk = ~mclk;

  rsml_strap_latch rsml_strap_latch_inst (.mclk(mclk), .nrst(nrst), .ce(ce), .procIdZero(procIdZero),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .funcOut(funcOut), .funcOe(funcOe),
    .bootExternalWait(bootExternalWait), .extIrqEnable(extIrqEnable), .extIrqEdge(extIrqEdge),
    .linkRxWidth4(linkRxWidth4), .cfgAlwaysWritable(cfgAlwaysWritable), .testMode(testMode),
    .pinsNormal(pinsNormal), .systemConfigReg(systemConfigReg), .sdramConfigReg(sdramConfigReg));
  rsml_board_model rsml_board_model_inst (.mclk(mclk), .strapEn(strapEn), .strapVal(strapVal),
    .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .padLevel(padIn));

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsrNext

  // unstrapped pins fall back to the reset pull: down on 3:0, up on 6:4
  function automatic logic [6:0] expStraps(input logic [6:0] en, input logic [6:0] val);
    return (en & val & 7'h0f) | 7'h70;
  endfunction : expStraps

  task automatic reportAndStop();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : reportAndStop

  task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never answers
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    logic [6:0] s, en, val;
    logic [31:0] rd, d;
    logic [11:0] adr;
    logic er, id;
    for (int it = 0; it < 8; it++) begin
      seed = lfsrNext(seed);
      // corners first: all defaults, then straps 3:0 overdriven high, the test straps left to their pull-up
      id = (it < 2) ? 1'b1 : seed[7];
      en = (it == 0) ? 7'h00 : (it == 1) ? 7'h7f : (seed[6:0] | (id ? 7'h00 : 7'h09));
      val = (it == 1) ? 7'h7f : seed[14:8];
      @(posedge mclk);
      nrst <= 1'b0;
      procIdZero <= id;
      strapEn <= en;
      strapVal <= val;
      funcOut <= seed[21:15];
      funcOe <= seed[28:22];
      repeat (6) @(posedge mclk);
      #1;
      `CHK("pullUp reset", 7'h70, pullUpEn)
      `CHK("pullDn reset", (id ? 7'h0f : 7'h06), pullDnEn)
      `CHK("padOe reset", 7'h00, padOe)
      s = expStraps(en, val);
      @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      strapVal <= ~val;
      #1;
      `CHK("modes", ({s[3:0], s[1]}), ({cfgAlwaysWritable, linkRxWidth4, extIrqEnable, bootExternalWait, extIrqEdge}))
      `CHK("testMode", s[6:4], testMode)
      `CHK("pullUp normal", (id ? 7'h09 : 7'h00), pullUpEn)
      `CHK("pullDn normal", 7'h00, pullDnEn)
      @(posedge mclk);
      #1;
      `CHK("pinsNormal early", 1'b0, pinsNormal)
      @(posedge mclk);
      #1;
      `CHK("pinsNormal", 1'b1, pinsNormal)
      @(posedge mclk);
      #1;
      `CHK("padOe normal", funcOe, padOe)
      `CHK("padOut normal", funcOut, padOut)
      apb(1'b0, rsml_pkg::OFS_STRAP_STATUS, 32'h0000_0000, rd, er);
      `CHK("status", (32'({1'b1, s})), rd)
      for (int r = 0; r < 2; r++) begin
        adr = r ? rsml_pkg::OFS_SDRAM_CFG : rsml_pkg::OFS_SYSTEM_CFG;
        apb(1'b1, adr, seed, rd, er);
        `CHK("first write err", 1'b0, er)
        apb(1'b1, adr, ~seed, rd, er);
        `CHK("second write err", ~s[3], er)
        apb(1'b0, adr, 32'h0000_0000, rd, er);
        `CHK("cfg readback", (s[3] ? ~seed : seed), rd)
      end
      d = s[3] ? ~seed : seed;
      `CHK("cfg ports", ({d, d}), ({systemConfigReg, sdramConfigReg}))
      apb(1'b0, rsml_pkg::OFS_LOCK_STATUS, 32'h0000_0000, rd, er);
      `CHK("lock", (32'({s[3], 2'b11})), rd)
      apb(1'b1, rsml_pkg::OFS_STRAP_STATUS, seed, rd, er);
      `CHK("status write err", 1'b1, er)
      // unmapped place answers with an error and zero data
      apb(1'b0, 12'h010, 32'h0000_0000, rd, er);
      `CHK("unmapped", 33'h1_0000_0000, ({er, rd}))
      `CHK("held", ({s, s[1]}), ({testMode, cfgAlwaysWritable, linkRxWidth4, extIrqEnable, bootExternalWait, extIrqEdge}))
      // enable low through the whole transfer: the write must not land
      ce <= 1'b0;
      apb(1'b1, rsml_pkg::OFS_SYSTEM_CFG, ~d, rd, er);
      #1;
      `CHK("frozen cfg", d, systemConfigReg)
      ce <= 1'b1;
    end
    reportAndStop();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    numErrors++;
    reportAndStop();
  end
endmodule : rsml_strap_latch_tb
`default_nettype wire
